// >>> design/rtc_counter_timing_trigger.sv
// RTC counters with periodic timing, match trigger and clock source switch
// ****************************************
// Functional notes
// RQ1 - Match high half to 2s, low half to ticks
// RQ2 - Sixteen-bit read-only tick counter
// RQ3 - Sixteen-bit read-only two-second counter
// RQ4 - Fourteen-bit day counter, upper bits read zero
// RQ5 - High load copies match value into days
// RQ6 - Low load copies halves into 2s, ticks
// RQ7 - Software powers crystal before selecting it
// RQ8 - Software tunes crystal current during startup
// RQ9 - Source switch completes after sixteen microseconds
// RQ10 - Timing mode runs only when enabled
// RQ11 - Elapsed period sets timing flag, interrupt
// RQ12 - Writing timing clear bit clears flag
// RQ13 - Trigger compares only when enabled
// RQ14 - Counters equal match sets trigger flag
// RQ15 - Writing trigger clear bit clears flag
// RQ16 - Software computes match from delay seconds
// RQ17 - Period codes select 0.125 to 16 seconds
// RQ18 - Ignore option drops bit zero from compare
// RQ19 - Clear bits read one while mode disabled
// RQ20 - Load bits return to zero after load
// RQ21 - Ticks carry to 2s, 2s to days
// ****************************************
`timescale 1ns/1ns
`default_nettype none

module rtc_counter_timing_trigger (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  // Register port
  input  wire rtc_pkg::bus_req_type      bus_req,
  output var  logic [31:0]               rdata,
  // Low-speed clock strobes, one sys_clk cycle per 32768 Hz edge
  input  wire logic                      internal_low_speed_osc_tick,
  input  wire logic                      external_low_speed_crystal_tick,
  // Crystal controls and events
  output var  rtc_pkg::crystal_ctrl_type crystal_ctrl,
  output var  logic                      periodic_irq,
  output var  logic                      match_irq
);
  import rtc_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [19:0] period_limit(input logic [2:0] code);
    period_limit = PERIOD_BASE << code; // RQ17
  endfunction

  function automatic logic match_hit(input logic [31:0] now,
                                     input logic [31:0] target,
                                     input logic        skip_lsb);
    logic [31:0] mask;
    mask      = {31'h7fff_ffff, ~skip_lsb}; // RQ18
    match_hit = ((now ^ target) & mask) == 32'h0000_0000; // RQ1
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [31:0]      match_value;
  logic [15:0]      tick_count;
  logic [15:0]      two_sec_count;
  logic [13:0]      day_count;
  logic             load_hi_pending;
  logic             load_lo_pending;
  logic             match_enable;
  logic             periodic_enable;
  logic             ignore_lsb_option;
  logic [2:0]       period_select;
  logic [19:0]      period_count;
  logic             source_select;
  logic             active_source;
  switch_state_type switch_state;
  logic [8:0]       switch_count;
  logic             match_equal_prev;
  logic             tick_evt;
  logic             day_wrap;
  logic             match_equal;
  logic             periodic_fire;
  logic             match_fire;
  logic             wr_mode;
  logic             wr_flag;
  logic [31:0]      next_rdata;

  assign wr_mode  = bus_req.wr && bus_req.addr == OFF_MODE;
  assign wr_flag  = bus_req.wr && bus_req.addr == OFF_FLAG;
  assign day_wrap = two_sec_count == DAY_UNITS - 16'h0001;

  // The crystal only counts once powered, so a premature select stalls time
  assign tick_evt = active_source
                    ? (external_low_speed_crystal_tick && crystal_ctrl.power_on)
                    : internal_low_speed_osc_tick;

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      match_value <= MATCH_RESET;
    end
    else if (bus_req.wr && bus_req.addr == OFF_MATCH)
    begin
      match_value <= bus_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      match_enable      <= 1'b0;
      periodic_enable   <= 1'b0;
      ignore_lsb_option <= 1'b0;
      period_select     <= PERIOD_RESET;
    end
    else if (wr_mode)
    begin
      match_enable      <= bus_req.wdata[MODE_MATCH_EN];
      periodic_enable   <= bus_req.wdata[MODE_PERIODIC_EN];
      ignore_lsb_option <= bus_req.wdata[MODE_IGNORE_LSB];
      period_select     <= bus_req.wdata[MODE_PERIOD_LSB +: 3];
    end
  end

  // Load requests live one cycle, then drop once the copy is done
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      load_hi_pending <= 1'b0;
      load_lo_pending <= 1'b0;
    end
    else
    begin
      load_hi_pending <= wr_mode && bus_req.wdata[MODE_LOAD_HI]; // RQ20
      load_lo_pending <= wr_mode && bus_req.wdata[MODE_LOAD_LO]; // RQ20
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crystal_ctrl  <= '{power_on: 1'b0, current_tune: TUNE_RESET};
      source_select <= 1'b0;
    end
    else if (bus_req.wr && bus_req.addr == OFF_CLK_CFG)
    begin
      crystal_ctrl.power_on     <= bus_req.wdata[CFG_POWER_ON];
      crystal_ctrl.current_tune <= bus_req.wdata[CFG_TUNE_LSB +: 2];
      source_select             <= bus_req.wdata[CFG_SOURCE];
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  // Counters power up undefined in silicon; zero here keeps simulation clean
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_count    <= COUNT_RESET;
      two_sec_count <= COUNT_RESET;
    end
    else if (load_lo_pending)
    begin
      two_sec_count <= match_value[31:16]; // RQ6
      tick_count    <= match_value[15:0]; // RQ6
    end
    else if (tick_evt)
    begin
      tick_count <= tick_count + 16'h0001; // RQ2
      if (tick_count == TICK_WRAP)
      begin
        two_sec_count <= day_wrap ? COUNT_RESET
                                  : two_sec_count + 16'h0001; // RQ3 RQ21
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      day_count <= DAY_RESET;
    end
    else if (load_hi_pending)
    begin
      day_count <= match_value[13:0]; // RQ5
    end
    else if (tick_evt && !load_lo_pending && tick_count == TICK_WRAP
             && day_wrap)
    begin
      day_count <= day_count + 14'h0001; // RQ21
    end
  end

  // ****************************************
  // Periodic timing
  // ****************************************
  // Count stops and restarts from zero whenever the mode is off
  assign periodic_fire = periodic_enable && tick_evt
                         && period_count >= period_limit(period_select)
                            - 20'h00001; // RQ10 RQ17

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      period_count <= 20'h00000;
    end
    else if (!periodic_enable || periodic_fire)
    begin
      period_count <= 20'h00000; // RQ10
    end
    else if (tick_evt)
    begin
      period_count <= period_count + 20'h00001;
    end
  end

  // A set arriving with a clear wins, so no event is lost
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      periodic_irq <= 1'b0;
    end
    else if (periodic_fire)
    begin
      periodic_irq <= 1'b1; // RQ11
    end
    else if (wr_flag && periodic_enable && bus_req.wdata[FLAG_PERIOD_CLR])
    begin
      periodic_irq <= 1'b0; // RQ12
    end
  end

  // ****************************************
  // Match trigger
  // ****************************************
  // Edge of equality, so a cleared flag is not set again by the same count
  assign match_equal = match_hit({two_sec_count, tick_count}, match_value,
                                 ignore_lsb_option);
  assign match_fire  = match_enable && match_equal && !match_equal_prev;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      match_equal_prev <= 1'b0;
    end
    else
    begin
      match_equal_prev <= match_equal && match_enable; // RQ13
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      match_irq <= 1'b0;
    end
    else if (match_fire)
    begin
      match_irq <= 1'b1; // RQ14
    end
    else if (wr_flag && match_enable && bus_req.wdata[FLAG_MATCH_CLR])
    begin
      match_irq <= 1'b0; // RQ15
    end
  end

  // ****************************************
  // Clock source switch
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      switch_state  <= SRC_IDLE;
      switch_count  <= 9'h000;
      active_source <= 1'b0;
    end
    else
    begin
      case (switch_state)
        SRC_IDLE:
        begin
          switch_count <= 9'h000;
          if (source_select != active_source)
          begin
            switch_state <= SRC_WAIT;
          end
        end
        SRC_WAIT:
        begin
          if (switch_count == 9'(SWITCH_CYCLES - 1))
          begin
            active_source <= source_select; // RQ9
            switch_state  <= SRC_IDLE;
          end
          else
          begin
            switch_count <= switch_count + 9'h001;
          end
        end
        default:
        begin
          switch_state <= SRC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        OFF_MATCH:   next_rdata = match_value;
        OFF_TICK:    next_rdata = {16'h0000, tick_count};
        OFF_TWO_SEC: next_rdata = {16'h0000, two_sec_count};
        OFF_DAY:     next_rdata = {18'h00000, day_count}; // RQ4
        OFF_MODE:
        begin
          next_rdata[MODE_LOAD_HI]          = load_hi_pending;
          next_rdata[MODE_LOAD_LO]          = load_lo_pending;
          next_rdata[MODE_MATCH_EN]         = match_enable;
          next_rdata[MODE_PERIODIC_EN]      = periodic_enable;
          next_rdata[MODE_IGNORE_LSB]       = ignore_lsb_option;
          next_rdata[MODE_PERIOD_LSB +: 3]  = period_select;
        end
        OFF_FLAG:
        begin
          next_rdata[FLAG_MATCH]      = match_irq;
          next_rdata[FLAG_PERIODIC]   = periodic_irq;
          next_rdata[FLAG_MATCH_CLR]  = !match_enable; // RQ19
          next_rdata[FLAG_PERIOD_CLR] = !periodic_enable; // RQ19
        end
        OFF_CLK_CFG:
        begin
          next_rdata[CFG_POWER_ON]      = crystal_ctrl.power_on;
          next_rdata[CFG_SOURCE]        = source_select;
          next_rdata[CFG_TUNE_LSB +: 2] = crystal_ctrl.current_tune;
          next_rdata[CFG_BUSY]          = switch_state == SRC_WAIT;
        end
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= 32'h0000_0000;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_load_low;
    @(posedge sys_clk) disable iff (!nrst)
    load_lo_pending |=> two_sec_count == $past(match_value[31:16])
                        && tick_count == $past(match_value[15:0]);
  endproperty
  a_load_low: assert property (p_load_low) // RQ6
    else $error("low load did not copy match value");

  property p_load_high;
    @(posedge sys_clk) disable iff (!nrst)
    load_hi_pending |=> day_count == $past(match_value[13:0]);
  endproperty
  a_load_high: assert property (p_load_high) // RQ5
    else $error("high load did not copy day value");

  property p_load_self_clear;
    @(posedge sys_clk) disable iff (!nrst)
    load_lo_pending && !wr_mode ##1 !wr_mode |=> !load_lo_pending;
  endproperty
  a_load_self_clear: assert property (p_load_self_clear) // RQ20
    else $error("load bit stayed set");

  property p_match_set;
    @(posedge sys_clk) disable iff (!nrst)
    match_enable && match_equal && !match_equal_prev |=> match_irq;
  endproperty
  a_match_set: assert property (p_match_set) // RQ14
    else $error("match did not set trigger flag");

  property p_match_gate;
    @(posedge sys_clk) disable iff (!nrst)
    !match_enable && !match_irq |=> !match_irq;
  endproperty
  a_match_gate: assert property (p_match_gate) // RQ13
    else $error("trigger flag set while disabled");

  property p_period_fire;
    @(posedge sys_clk) disable iff (!nrst)
    periodic_enable && tick_evt
      && period_count == period_limit(period_select) - 20'h00001
      |=> periodic_irq && period_count == 20'h00000;
  endproperty
  a_period_fire: assert property (p_period_fire) // RQ11
    else $error("period end did not set timing flag");

  property p_period_gate;
    @(posedge sys_clk) disable iff (!nrst)
    !periodic_enable && !periodic_irq |=> !periodic_irq;
  endproperty
  a_period_gate: assert property (p_period_gate) // RQ10
    else $error("timing flag set while disabled");

  property p_period_clear;
    @(posedge sys_clk) disable iff (!nrst)
    wr_flag && periodic_enable && bus_req.wdata[FLAG_PERIOD_CLR]
      && !periodic_fire |=> !periodic_irq;
  endproperty
  a_period_clear: assert property (p_period_clear) // RQ12
    else $error("timing flag not cleared");

  property p_clear_reads_one;
    @(posedge sys_clk) disable iff (!nrst)
    bus_req.rd && bus_req.addr == OFF_FLAG && !match_enable
      |=> rdata[FLAG_MATCH_CLR];
  endproperty
  a_clear_reads_one: assert property (p_clear_reads_one) // RQ19
    else $error("clear bit not one while disabled");

  property p_switch_delay;
    @(posedge sys_clk) disable iff (!nrst)
    active_source != $past(active_source)
      |-> $past(switch_count) == 9'(SWITCH_CYCLES - 1);
  endproperty
  a_switch_delay: assert property (p_switch_delay) // RQ9
    else $error("source switched too early");

  property p_day_upper_zero;
    @(posedge sys_clk) disable iff (!nrst)
    bus_req.rd && bus_req.addr == OFF_DAY |=> rdata[31:14] == 18'h00000;
  endproperty
  a_day_upper_zero: assert property (p_day_upper_zero) // RQ4
    else $error("day register upper bits not zero");

  property p_two_sec_carry;
    @(posedge sys_clk) disable iff (!nrst)
    tick_evt && !load_lo_pending && tick_count == TICK_WRAP && !day_wrap
      |=> two_sec_count == $past(two_sec_count) + 16'h0001
          && tick_count == COUNT_RESET;
  endproperty
  a_two_sec_carry: assert property (p_two_sec_carry) // RQ21
    else $error("tick wrap did not carry");

endmodule

`default_nettype wire

// >>> design/rtc_pkg.sv
// Package: register map, field layout, reset values and timing for the RTC
`default_nettype none
package rtc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_MATCH    = 8'h00;
  localparam logic [7:0] OFF_TICK     = 8'h04;
  localparam logic [7:0] OFF_TWO_SEC  = 8'h08;
  localparam logic [7:0] OFF_DAY      = 8'h0c;
  localparam logic [7:0] OFF_MODE     = 8'h10;
  localparam logic [7:0] OFF_FLAG     = 8'h14;
  localparam logic [7:0] OFF_CLK_CFG  = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_LOAD_HI     = 7;
  localparam int MODE_LOAD_LO     = 6;
  localparam int MODE_MATCH_EN    = 5;
  localparam int MODE_PERIODIC_EN = 4;
  localparam int MODE_IGNORE_LSB  = 3;
  localparam int MODE_PERIOD_LSB  = 0;
  localparam int FLAG_MATCH       = 7;
  localparam int FLAG_PERIODIC    = 6;
  localparam int FLAG_MATCH_CLR   = 5;
  localparam int FLAG_PERIOD_CLR  = 4;
  localparam int CFG_POWER_ON     = 0;
  localparam int CFG_SOURCE       = 1;
  localparam int CFG_TUNE_LSB     = 2;
  localparam int CFG_BUSY         = 7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] MATCH_RESET  = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [13:0] DAY_RESET    = 14'h0000;
  localparam logic [2:0]  PERIOD_RESET = 3'h2;
  localparam logic [1:0]  TUNE_RESET   = 2'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          SYS_CLK_NS      = 50;
  localparam int          SWITCH_WAIT_NS  = 16000;
  localparam int          SWITCH_CYCLES   =
    (SWITCH_WAIT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [15:0] DAY_UNITS       = 16'ha8c0;
  localparam logic [15:0] TICK_WRAP       = 16'hffff;
  localparam logic [19:0] PERIOD_BASE     = 20'h01000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic       power_on;
    logic [1:0] current_tune;
  } crystal_ctrl_type;

  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_WAIT = 2'b01
  } switch_state_type;

endpackage

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the RTC counter, timing and trigger block
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Compare macro
// ****************************************
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t ns: got %h expected %h", \
               $time, got, exp); \
    end \
  end

module testbench;
  import rtc_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic             sys_clk;
  logic             nrst;
  bus_req_type      bus_req;
  logic [31:0]      rdata;
  logic             int_tick;
  logic             ext_tick;
  crystal_ctrl_type crystal_ctrl;
  logic             periodic_irq;
  logic             match_irq;
  int               error_cnt;
  int               checked;
  logic [31:0]      r;
  logic [31:0]      m;
  logic [31:0]      v;

  rtc_counter_timing_trigger u_dut (
    .sys_clk                         (sys_clk),
    .nrst                            (nrst),
    .bus_req                         (bus_req),
    .rdata                           (rdata),
    .internal_low_speed_osc_tick     (int_tick),
    .external_low_speed_crystal_tick (ext_tick),
    .crystal_ctrl                    (crystal_ctrl),
    .periodic_irq                    (periodic_irq),
    .match_irq                       (match_irq)
  );

  // ****************************************
  // Clock, time-zero values
  // ****************************************
  initial
  begin
    sys_clk   = 1'b0;
    nrst      = 1'b0;
    bus_req   = '0;
    int_tick  = 1'b0;
    ext_tick  = 1'b0;
    error_cnt = 0;
    checked   = 0;
  end

  always #25 sys_clk = ~sys_clk;

  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic [31:0] exp_day(input logic [31:0] val);
    exp_day = {18'h0, val[13:0]};
  endfunction

  // Match value for a delay in whole seconds from a given count
  function automatic logic [31:0] target_of(input logic [31:0] now,
                                            input int          secs);
    target_of = now + 32'(secs) * 32'h0000_8000;
  endfunction

  function automatic int period_len(input int sel);
    period_len = 4096 << sel;
  endfunction

  function automatic logic [31:0] exp_flags(input logic mf, input logic pf,
                                            input logic men, input logic pen);
    exp_flags = {24'h0, mf, pf, ~men, ~pen, 4'h0};
  endfunction

  // ****************************************
  // Bus and stimulus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // Strobes spaced one idle cycle apart, well above the minimum spacing
  task automatic tick(input int n, input logic ext);
    repeat (n)
    begin
      @(posedge sys_clk);
      if (ext)
        ext_tick <= 1'b1;
      else
        int_tick <= 1'b1;
      @(posedge sys_clk);
      ext_tick <= 1'b0;
      int_tick <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial
  begin
    #(50 * 60000);
    error_cnt++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    conclude;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'hee2d));
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);

    // Reset values, unmapped place
    chk_rd(OFF_MATCH, 32'h0);
    chk_rd(OFF_MODE, 32'h02);
    chk_rd(OFF_FLAG, exp_flags(0, 0, 0, 0));
    chk_rd(OFF_DAY, 32'h0);
    chk_rd(8'h40, 32'h0);
    `CHK(crystal_ctrl, 3'b000)

    // Random loads of both halves; read-only places ignore writes
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      wr(OFF_MATCH, r);
      chk_rd(OFF_MATCH, r);
      wr(OFF_MODE, 32'hc2);
      chk_rd(OFF_MODE, 32'h02);
      chk_rd(OFF_TICK, {16'h0, r[15:0]});
      chk_rd(OFF_TWO_SEC, {16'h0, r[31:16]});
      chk_rd(OFF_DAY, exp_day(r));
      wr(OFF_TICK, ~r);
      wr(OFF_DAY, ~r);
      chk_rd(OFF_TICK, {16'h0, r[15:0]});
      chk_rd(OFF_DAY, exp_day(r));
    end

    // Plain carry of a tick wrap into the two-second count
    v = {16'($urandom) & 16'h7fff, 16'hffff};
    wr(OFF_MATCH, v);
    wr(OFF_MODE, 32'h42);
    tick(1, 1'b0);
    chk_rd(OFF_TICK, 32'h0);
    chk_rd(OFF_TWO_SEC, {16'h0, v[31:16] + 16'h0001});

    // Carry at the last tick of the last two-second unit of a day
    r = {18'h0, 14'($urandom) & 14'h3ffe};
    wr(OFF_MATCH, {DAY_UNITS - 16'h1, 16'hffff});
    wr(OFF_MODE, 32'h42);
    wr(OFF_MATCH, r);
    wr(OFF_MODE, 32'h82);
    tick(1, 1'b0);
    chk_rd(OFF_TICK, 32'h0);
    chk_rd(OFF_TWO_SEC, 32'h0);
    chk_rd(OFF_DAY, r + 32'h1);

    // Periodic mode: shortest code, disabled run, next code
    wr(OFF_MODE, 32'h10);
    tick(period_len(0) - 1, 1'b0);
    `CHK(periodic_irq, 1'b0)
    tick(1, 1'b0);
    `CHK(periodic_irq, 1'b1)
    chk_rd(OFF_FLAG, exp_flags(0, 1, 0, 1));
    wr(OFF_FLAG, 32'h10);
    @(negedge sys_clk);
    `CHK(periodic_irq, 1'b0)
    wr(OFF_MODE, 32'h00);
    tick(period_len(0), 1'b0);
    `CHK(periodic_irq, 1'b0)
    wr(OFF_MODE, 32'h11);
    tick(period_len(1) - 1, 1'b0);
    `CHK(periodic_irq, 1'b0)
    tick(1, 1'b0);
    `CHK(periodic_irq, 1'b1)
    wr(OFF_FLAG, 32'h10);
    wr(OFF_MODE, 32'h02);

    // Trigger: passes unnoticed while disabled, fires when enabled
    m = target_of({16'($urandom), 16'h1000 | {4'h0, 12'($urandom)}}
                  & 32'hfffffffe, 1);
    wr(OFF_MATCH, m - 32'h3);
    wr(OFF_MODE, 32'h42);
    wr(OFF_MATCH, m);
    tick(3, 1'b0);
    `CHK(match_irq, 1'b0)
    wr(OFF_MATCH, m + 32'h2);
    wr(OFF_MODE, 32'h22);
    tick(1, 1'b0);
    `CHK(match_irq, 1'b0)
    tick(1, 1'b0);
    `CHK(match_irq, 1'b1)
    chk_rd(OFF_FLAG, exp_flags(1, 0, 1, 0));
    wr(OFF_FLAG, 32'h20);
    @(negedge sys_clk);
    `CHK(match_irq, 1'b0)
    // Odd target is met one tick early once bit zero is ignored
    wr(OFF_MATCH, m + 32'h5);
    wr(OFF_MODE, 32'h2a);
    tick(1, 1'b0);
    `CHK(match_irq, 1'b0)
    tick(1, 1'b0);
    `CHK(match_irq, 1'b1)
    wr(OFF_FLAG, 32'h20);
    wr(OFF_MODE, 32'h02);

    // Crystal: powered and tuned before it is selected
    wr(OFF_CLK_CFG, 32'h0d);
    @(negedge sys_clk);
    `CHK(crystal_ctrl, 3'b111)
    wr(OFF_CLK_CFG, 32'h0f);
    chk_rd(OFF_CLK_CFG, 32'h8f);
    repeat (200) @(posedge sys_clk);
    chk_rd(OFF_CLK_CFG, 32'h8f);
    repeat (130) @(posedge sys_clk);
    chk_rd(OFF_CLK_CFG, 32'h0f);
    // Once settled, drive current goes back to the rated setting
    wr(OFF_CLK_CFG, 32'h07);
    chk_rd(OFF_CLK_CFG, 32'h07);
    `CHK(crystal_ctrl, 3'b101)
    rd(OFF_TICK, v);
    tick(3, 1'b0);
    chk_rd(OFF_TICK, v);
    tick(3, 1'b1);
    chk_rd(OFF_TICK, {16'h0, v[15:0] + 16'h3});

    conclude;
  end

endmodule

`default_nettype wire
